// ---- core/rdap_core.sv ----
// Module: day alarm registers and first prescale stage with control register and interrupt.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1 - Bit 7 of each day alarm enables that field in alarm matching.
// RULE2 - Weekday alarm keeps bits 2-0, range 0-6; bits 6-3 read zero.
// RULE3 - Binary month-day alarm keeps bits 4-0; bits 6-5 read zero.
// RULE4 - Decimal month-day alarm keeps tens in 5-4, units in 3-0; bit 6 zero.
// RULE5 - Divide select in bits 13-11 picks divide by 2 up to 256.
// RULE6 - Calendar mode forces stage output divide 256 and second stage 128.
// RULE7 - Freeze bit 8 resets to one, holds the stage, ignored in calendar mode.
// RULE8 - In calendar mode the global freeze stops the stage.
// RULE9 - Interval field in bits 4-2 picks the tap that sets the flag.
// RULE10 - Bit 1 is the interrupt enable, reset zero.
// RULE11 - Bit 0 is the event flag, set by the selected tap event.
// RULE12 - Reserved control bits read zero.
// RULE13 - Effective divide and interval held during deep sleep until lock release.
// RULE14 - Software rewrites divide and interval before releasing the lock.
// RULE15 - Interrupt request is high while flag and enable are both one.
module rdap_core #(
    parameter int CNT_W = rdap_pkg::CNT_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic lf_tick_i,
    input wire logic calendar_mode_i,
    input wire logic decimal_format_i,
    input wire logic global_count_freeze_i,
    input wire logic lowpower_io_lock_i,
    input wire logic [rdap_pkg::ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic weekday_alarm_en_o,
    output logic [2:0] weekday_alarm_o,
    output logic monthday_alarm_en_o,
    output logic [5:0] monthday_alarm_o,
    output logic stage0_out_tick_o,
    output logic stage0_irq_o,
    output logic irq_o
);
    //////////////////////////////////////////////////////////////////////////
    rdap_pkg::rdap_bus_req_t req;
    logic [7:0] weekday_alarm_ff;
    logic [7:0] monthday_alarm_ff;
    rdap_pkg::rdap_cfg_t cfg_ff;
    rdap_pkg::rdap_cfg_t eff_cfg_ff;
    logic stage0_freeze_ff;
    logic stage0_interrupt_enable_ff;
    logic stage0_event_flag_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [rdap_pkg::EV_W-1:0] stat_ff;
    logic [rdap_pkg::EV_W-1:0] mask_ff;
    logic [15:0] nxt_rdata;
    logic run;
    logic [2:0] div_eff;
    logic tap_ev;
    logic out_ev;
    logic [15:0] ctl_view;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // True when a tap of the given code toggles from one to zero on this count step.
    function automatic logic tap_fall(input logic [CNT_W-1:0] cur,
                                      input logic [CNT_W-1:0] nxt,
                                      input logic [2:0] code);
        tap_fall = cur[code] & ~nxt[code];
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Alarm registers.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            weekday_alarm_ff <= 8'h00;
        end else if (req.wr && req.addr == rdap_pkg::ADR_WEEKDAY) begin
            weekday_alarm_ff <= req.wdata[7:0] & rdap_pkg::WDAY_MASK; // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            monthday_alarm_ff <= 8'h00;
        end else if (req.wr && req.addr == rdap_pkg::ADR_MDAY) begin
            if (decimal_format_i) begin
                monthday_alarm_ff <= req.wdata[7:0] & rdap_pkg::MDAY_DEC_MASK; // [RULE4]
            end else begin
                monthday_alarm_ff <= req.wdata[7:0] & rdap_pkg::MDAY_BIN_MASK; // [RULE3]
            end
        end
    end

    // A cleared enable bit drops the field from alarm matching downstream.
    assign weekday_alarm_en_o = weekday_alarm_ff[rdap_pkg::AE_BIT]; // [RULE1]
    assign weekday_alarm_o = weekday_alarm_ff[2:0];
    assign monthday_alarm_en_o = monthday_alarm_ff[rdap_pkg::AE_BIT]; // [RULE1]
    assign monthday_alarm_o = monthday_alarm_ff[5:0];

    //////////////////////////////////////////////////////////////////////////
    // Control register.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_ff <= '{div_sel: rdap_pkg::DIV_RST, ip_sel: rdap_pkg::IP_RST};
            stage0_freeze_ff <= rdap_pkg::FRZ_RST; // [RULE7]
            stage0_interrupt_enable_ff <= rdap_pkg::IE_RST; // [RULE10]
        end else if (req.wr && req.addr == rdap_pkg::ADR_PS0CTL) begin
            cfg_ff.div_sel <= req.wdata[rdap_pkg::DIV_LSB +: 3];
            cfg_ff.ip_sel <= req.wdata[rdap_pkg::IP_LSB +: 3];
            stage0_freeze_ff <= req.wdata[rdap_pkg::FRZ_BIT];
            stage0_interrupt_enable_ff <= req.wdata[rdap_pkg::IE_BIT]; // [RULE10]
        end
    end

    // The effective setting tracks the register only while the low-power lock is open.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            eff_cfg_ff <= '{div_sel: rdap_pkg::DIV_RST, ip_sel: rdap_pkg::IP_RST};
        end else if (!lowpower_io_lock_i) begin
            eff_cfg_ff <= cfg_ff; // [RULE13]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Counter.
    always_comb begin
        if (calendar_mode_i) begin
            run = ~global_count_freeze_i; // [RULE8] [RULE7]
            div_eff = rdap_pkg::CAL_DIV_CODE; // [RULE6]
        end else begin
            run = ~stage0_freeze_ff; // [RULE7]
            div_eff = eff_cfg_ff.div_sel; // [RULE5]
        end
    end

    assign nxt_cnt = cnt_ff + CNT_W'(1);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (run && lf_tick_i) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign tap_ev = run & lf_tick_i & tap_fall(cnt_ff, nxt_cnt, eff_cfg_ff.ip_sel); // [RULE9]
    assign out_ev = run & lf_tick_i & tap_fall(cnt_ff, nxt_cnt, div_eff); // [RULE5] [RULE6]

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage0_out_tick_o <= 1'b0;
        end else begin
            stage0_out_tick_o <= out_ev;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Event flag: a tap event in the same cycle as a write wins.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage0_event_flag_ff <= 1'b0;
        end else if (tap_ev) begin
            stage0_event_flag_ff <= 1'b1; // [RULE11]
        end else if (req.wr && req.addr == rdap_pkg::ADR_PS0CTL) begin
            stage0_event_flag_ff <= req.wdata[rdap_pkg::FLG_BIT]; // [RULE11]
        end
    end

    assign stage0_irq_o = stage0_event_flag_ff & stage0_interrupt_enable_ff; // [RULE15]

    //////////////////////////////////////////////////////////////////////////
    // Sticky status and mask.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_ff <= '0;
        end else begin
            for (int i = 0; i < rdap_pkg::EV_W; i++) begin
                if ((i == rdap_pkg::EV_TAP && tap_ev) ||
                        (i == rdap_pkg::EV_STAGE_OUT && out_ev)) begin
                    stat_ff[i] <= 1'b1;
                end else if (req.wr && req.addr == rdap_pkg::ADR_IRQ_STAT && req.wdata[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_ff <= '0;
        end else if (req.wr && req.addr == rdap_pkg::ADR_IRQ_MASK) begin
            mask_ff <= req.wdata[rdap_pkg::EV_W-1:0];
        end
    end

    assign irq_o = |(stat_ff & mask_ff);

    //////////////////////////////////////////////////////////////////////////
    // Read path.
    always_comb begin
        ctl_view = 16'h0000; // [RULE12]
        ctl_view[rdap_pkg::DIV_LSB +: 3] = cfg_ff.div_sel;
        ctl_view[rdap_pkg::FRZ_BIT] = stage0_freeze_ff;
        ctl_view[rdap_pkg::IP_LSB +: 3] = cfg_ff.ip_sel;
        ctl_view[rdap_pkg::IE_BIT] = stage0_interrupt_enable_ff;
        ctl_view[rdap_pkg::FLG_BIT] = stage0_event_flag_ff;
    end

    always_comb begin
        nxt_rdata = 16'h0000;
        if (req.addr == rdap_pkg::ADR_WEEKDAY) begin
            nxt_rdata = {8'h00, weekday_alarm_ff};
        end else if (req.addr == rdap_pkg::ADR_MDAY) begin
            nxt_rdata = {8'h00, monthday_alarm_ff};
        end else if (req.addr == rdap_pkg::ADR_PS0CTL) begin
            nxt_rdata = ctl_view;
        end else if (req.addr == rdap_pkg::ADR_IRQ_STAT) begin
            nxt_rdata = {14'h0000, stat_ff};
        end else if (req.addr == rdap_pkg::ADR_IRQ_MASK) begin
            nxt_rdata = {14'h0000, mask_ff};
        end else if (req.addr == rdap_pkg::ADR_STATE) begin
            nxt_rdata = 16'(cnt_ff);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (req.rd) begin
            rdata_o <= nxt_rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule

// ---- core/rdap_pkg.sv ----
// Package: register map, field positions, reset values and types of the day alarm and prescaler block.
package rdap_pkg;
    localparam int ADDR_W = 4;
    // Register indices chosen for this block.
    localparam logic [3:0] ADR_WEEKDAY = 4'h0;
    localparam logic [3:0] ADR_MDAY = 4'h1;
    localparam logic [3:0] ADR_PS0CTL = 4'h2;
    localparam logic [3:0] ADR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADR_STATE = 4'h5;
    // Alarm register fields.
    localparam int AE_BIT = 7;
    localparam logic [7:0] WDAY_MASK = 8'h87;
    localparam logic [7:0] MDAY_BIN_MASK = 8'h9f;
    localparam logic [7:0] MDAY_DEC_MASK = 8'hbf;
    // Prescaler stage 0 control fields.
    localparam int DIV_LSB = 11;
    localparam int FRZ_BIT = 8;
    localparam int IP_LSB = 2;
    localparam int IE_BIT = 1;
    localparam int FLG_BIT = 0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] IP_RST = 3'h0;
    localparam logic FRZ_RST = 1'b1;
    localparam logic IE_RST = 1'b0;
    localparam logic [2:0] CAL_DIV_CODE = 3'h7;
    localparam int CNT_W = 8;
    // Interrupt status bits.
    localparam int EV_TAP = 0;
    localparam int EV_STAGE_OUT = 1;
    localparam int EV_W = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } rdap_bus_req_t;

    typedef struct packed {
        logic [2:0] div_sel;
        logic [2:0] ip_sel;
    } rdap_cfg_t;
endpackage

// ---- verif/rdap_properties.sv ----
// Checker: port-level properties of the day alarm and prescaler block.
`timescale 1ns/100ps
module rdap_properties (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic calendar_mode_i,
    input wire logic global_count_freeze_i,
    input wire logic [rdap_pkg::ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic weekday_alarm_en_o,
    input wire logic [2:0] weekday_alarm_o,
    input wire logic stage0_out_tick_o,
    input wire logic stage0_irq_o
);
    logic [15:0] wdata_ff;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge sys_clk_i) begin
        wdata_ff <= wdata_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_read_idle: assert property (!rd_i |=> rdata_o == 16'h0)
        else $error("read data not zero outside a read answer");
    a_wday_zero: assert property (rd_i && addr_i == rdap_pkg::ADR_WEEKDAY |=>
        rdata_o[15:8] == 8'h0 && rdata_o[6:3] == 4'h0) else $error("weekday zero bits set");
    a_mday_zero: assert property (rd_i && addr_i == rdap_pkg::ADR_MDAY |=>
        rdata_o[15:8] == 8'h0 && !rdata_o[6]) else $error("month-day zero bits set");
    a_ctl_reserved: assert property (rd_i && addr_i == rdap_pkg::ADR_PS0CTL |=>
        (rdata_o & 16'hc6e0) == 16'h0) else $error("reserved control bits set");
    a_wday_out: assert property (wr_i && addr_i == rdap_pkg::ADR_WEEKDAY |=>
        weekday_alarm_en_o == wdata_ff[7] && weekday_alarm_o == wdata_ff[2:0])
        else $error("weekday alarm outputs do not follow the write");
    a_ie_off: assert property (wr_i && addr_i == rdap_pkg::ADR_PS0CTL
        && !wdata_i[1] |=> !stage0_irq_o)
        else $error("stage interrupt high with enable cleared");
    a_irq_on: assert property (wr_i && addr_i == rdap_pkg::ADR_PS0CTL
        && wdata_i[1:0] == 2'h3 |=> stage0_irq_o)
        else $error("stage interrupt low with flag and enable set");
    a_cal_freeze: assert property ((calendar_mode_i && global_count_freeze_i)[*3]
        |=> !stage0_out_tick_o) else $error("stage output ticks while globally frozen");
endmodule

// ---- verif/rdap_core_test.sv ----
// Testbench: day alarm registers and first prescale stage against a bench model.
`timescale 1ns/100ps
module rdap_core_test;
    logic sys_clk_i = 0, rst_i = 1, tk = 0, cal = 0, dec = 0, gfz = 0, lk = 0, wr = 0, rd = 0;
    logic [3:0] ad = 4'h0;
    logic [15:0] wd = 16'h0, rdat, d;
    logic otk, sirq, irq, wae, mae;
    logic [2:0] wao;
    logic [5:0] mao;
    int bad_count = 0, n_checks = 0, cnt = 0, n_out = 0, o_exp = 0, x = 93;
    int ip = 0, dv = 0, ipe = 0, dve = 0, fz = 1, ie = 0, fl = 0, st = 0, mk = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (otk === 1'b1) n_out++;
    rdap_core rdap_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lf_tick_i(tk),
        .calendar_mode_i(cal), .decimal_format_i(dec), .global_count_freeze_i(gfz),
        .lowpower_io_lock_i(lk), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdat), .weekday_alarm_en_o(wae), .weekday_alarm_o(wao),
        .monthday_alarm_en_o(mae), .monthday_alarm_o(mao), .stage0_out_tick_o(otk),
        .stage0_irq_o(sirq), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x & 32'h7fffffff;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        ad <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        if (a == rdap_pkg::ADR_PS0CTL) begin
            {dv, fz, ip, ie, fl} = {29'h0, v[13:11], 31'h0, v[8], 29'h0, v[4:2], 31'h0, v[1],
                31'h0, v[0]};
        end
        if (a == rdap_pkg::ADR_IRQ_STAT) st = st & ~int'(v[1:0]);
        if (a == rdap_pkg::ADR_IRQ_MASK) mk = v[1:0];
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        ad <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        // Read data stand for one cycle and are taken at the edge that closes it.
        @(posedge sys_clk_i);
        chk(rdat, e);
    endtask
    // Ticks come every other cycle, never beside a register access.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            tk <= 1'b1;
            @(posedge sys_clk_i);
            tk <= 1'b0;
            if (!lk) begin
                ipe = ip;
                dve = dv;
            end
            if (cal ? !gfz : !fz) begin
                cnt++;
                if (cnt % (2 << ipe) == 0) begin
                    fl = 1;
                    st = st | 1;
                end
                if (cnt % (2 << (cal ? 7 : dve)) == 0) begin
                    o_exp++;
                    st = st | 2;
                end
            end
        end
        repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic chk_all();
        rdc(rdap_pkg::ADR_PS0CTL, 16'(dv << 11 | fz << 8 | ip << 2 | ie << 1 | fl));
        rdc(rdap_pkg::ADR_IRQ_STAT, 16'(st));
        rdc(rdap_pkg::ADR_STATE, 16'(cnt % 256));
        chk(16'(sirq), 16'(fl & ie));
        chk(16'(irq), 16'((st & mk) != 0));
        chk(16'(n_out), 16'(o_exp));
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(rdap_pkg::ADR_PS0CTL, 16'h0100);
        rdc(4'hf, 16'h0000);
        wrt(rdap_pkg::ADR_PS0CTL, 16'hffff);
        rdc(rdap_pkg::ADR_PS0CTL, 16'h391f);
        repeat (4) begin
            d = 16'(rnd());
            dec <= d[8];
            wrt(rdap_pkg::ADR_WEEKDAY, d);
            rdc(rdap_pkg::ADR_WEEKDAY, d & 16'h0087);
            chk(16'({wae, 4'h0, wao}), d & 16'h0087);
            wrt(rdap_pkg::ADR_MDAY, d);
            rdc(rdap_pkg::ADR_MDAY, d & (d[8] ? 16'h00bf : 16'h009f));
            chk(16'({mae, 1'b0, mao}), d & (d[8] ? 16'h00bf : 16'h009f));
        end
        wrt(rdap_pkg::ADR_IRQ_MASK, 16'h0003);
        for (int k = 0; k < 8; k++) begin
            wrt(rdap_pkg::ADR_PS0CTL, 16'(k << 11 | (7 - k) << 2 | 2));
            wrt(rdap_pkg::ADR_IRQ_STAT, 16'h0003);
            ticks(rnd() % 300 + 1);
            chk_all();
        end
        wrt(rdap_pkg::ADR_PS0CTL, 16'h0102);
        ticks(5);
        chk_all();
        cal <= 1'b1;
        gfz <= 1'b1;
        ticks(5);
        chk_all();
        gfz <= 1'b0;
        ticks(300);
        chk_all();
        cal <= 1'b0;
        wrt(rdap_pkg::ADR_PS0CTL, 16'h0002);
        lk <= 1'b1;
        wrt(rdap_pkg::ADR_PS0CTL, 16'h001e);
        ticks(3);
        chk_all();
        lk <= 1'b0;
        ticks(20);
        chk_all();
        // A reset in mid-run must bring the weekday alarm, control, status and count registers back to their reset state.
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        fz = 1;
        dv = 0;
        ip = 0;
        ie = 0;
        fl = 0;
        st = 0;
        mk = 0;
        cnt = 0;
        rdc(rdap_pkg::ADR_WEEKDAY, 16'h0000);
        chk_all();
        print_verdict();
    end
    initial begin
        #3000000;
        bad_count++;
        print_verdict();
    end
endmodule
bind rdap_core rdap_properties rdap_properties_i (.sys_clk_i, .rst_i, .calendar_mode_i,
    .global_count_freeze_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .weekday_alarm_en_o,
    .weekday_alarm_o, .stage0_out_tick_o, .stage0_irq_o);
